// ### itc_map.svh
// Overview of operation
// RULE1: per-source request, enable, sixteen-level priority register
// RULE2: only strictly higher priority preempts a service
// RULE3: each request routed to vector or channel
// RULE4: channel service: one cycle, move, bump pointer
// RULE5: counter decrements unless continuous; zero gives interrupt
// RULE6: eight independent event transfer channels
// RULE7: fast inputs detect rising, falling or both
// RULE8: software trap 0x00-0x7F vectors at four times
// RULE9: external inputs 0-7 use traps 0x18-0x1F
// RULE10: timers use 0x22-0x26, capture reload 0x27
// RULE11: serial, sync port, watchdog use fixed traps
// RULE12: interrupt response between 200 and 480 ns
// RULE13: hardware trap branches at once, unmaskable
// RULE14: each hardware trap sets its own flag
// RULE15: trap preempts unless higher trap in service; the code also holds it off while a trap of equal class is in service
// RULE16: trap service not preempted by interrupts, channels
// RULE17: class A vectors 0x08, 0x10, 0x18
// RULE18: class B traps share vector 0x28
// RULE19: resets vector 0x0000; traps 0x0B-0x0F reserved
// RULE20: stack pointer checked against limits each access
// RULE21: request set by event, cleared on acceptance
`ifndef ITC_MAP_SVH
`define ITC_MAP_SVH
// sizes
`define ITC_NSRC 20
`define ITC_NEXT 8
`define ITC_NCH 8
`define ITC_EDGE_W 2
`define ITC_EDGE_R 0
`define ITC_EDGE_F 1
// apb byte addresses
`define ITC_A_SRC 12'h000
`define ITC_A_SRC_END 12'h050
`define ITC_A_CH 12'h100
`define ITC_A_CH_END 12'h180
`define ITC_A_TFR 12'h200
`define ITC_A_SUL 12'h204
`define ITC_A_SLL 12'h208
`define ITC_A_STAT 12'h20C
`define ITC_A_EDGE 12'h210
`define ITC_SRC_IDX 6:2
`define ITC_CH_IDX 6:4
`define ITC_CH_FLD 3:2
`define ITC_FLD_SRC 2'h0
`define ITC_FLD_DST 2'h1
`define ITC_FLD_CNT 2'h2
`define ITC_FLD_CTL 2'h3
// source control fields
`define ITC_F_REQ 0
`define ITC_F_EN 1
`define ITC_F_PRIO 5:2
`define ITC_F_ROUTE 6
`define ITC_F_CH 9:7
`define ITC_SCTL_W 10
// source indices
`define ITC_SRC_TIM 5'h08
`define ITC_SRC_STX 5'h0E
`define ITC_SRC_SRX 5'h0F
`define ITC_SRC_SER 5'h10
`define ITC_SRC_STB 5'h11
`define ITC_SRC_SSP 5'h12
// trap numbers
`define ITC_TN_RST 7'h00
`define ITC_TN_NMI 7'h02
`define ITC_TN_STO 7'h04
`define ITC_TN_STU 7'h06
`define ITC_TN_CLB 7'h0A
`define ITC_TN_EXT0 7'h18
`define ITC_TN_TIM2 7'h22
`define ITC_TN_STX 7'h2A
`define ITC_TN_SRX 7'h2B
`define ITC_TN_SER 7'h2C
`define ITC_TN_STB 7'h47
`define ITC_TN_SSP 7'h41
`define ITC_TN_OWD 7'h43
// trap flag bits and pending classes
`define ITC_TF_NMI 15
`define ITC_TF_STO 14
`define ITC_TF_STU 13
`define ITC_TF_UND 7
`define ITC_TF_PRT 3
`define ITC_TF_OPA 2
`define ITC_TF_INA 1
`define ITC_TF_BUS 0
`define ITC_TP_NMI 3
`define ITC_TP_STO 2
`define ITC_TP_STU 1
`define ITC_TP_CLB 0
`define ITC_TL_A1 2'h3
`define ITC_TL_A2 2'h2
`define ITC_TL_B 2'h1
`define ITC_LVL_TOP 4'hF
// pointer steps
`define ITC_INC_B 16'h0001
`define ITC_INC_W 16'h0002
// response timing
`define ITC_CLK_NS 10
`define ITC_RESP_MIN_NS 200
`define ITC_RESP_MAX_NS 480
`define ITC_RESP_CYC ((`ITC_RESP_MIN_NS + `ITC_CLK_NS - 1) / `ITC_CLK_NS)
`define ITC_RESP_MAX_CYC (`ITC_RESP_MAX_NS / `ITC_CLK_NS)
`endif

// ### itc_pkg.sv
package itc_pkg;
  // hardware trap conditions from the core
  typedef struct packed {
    logic nmi;
    logic undef_opc;
    logic prot_fault;
    logic ill_opa;
    logic ill_ina;
    logic ill_bus;
  } itc_hwtrap_t;
  // core side inputs
  typedef struct packed {
    logic        ack;
    logic [3:0]  lvl;
    logic        trap_ret;
    logic        sw_trap;
    logic [6:0]  sw_num;
    logic        stk_acc;
    logic [15:0] sp;
    logic        sw_reset;
    logic        wdt_ovf;
  } itc_cpu_t;
  // entry presented to the core
  typedef struct packed {
    logic        req;
    logic        irq;
    logic        trap;
    logic [6:0]  num;
    logic [15:0] vec;
    logic [3:0]  lvl;
  } itc_entry_t;
  // one stolen transfer cycle
  typedef struct packed {
    logic        valid;
    logic        word;
    logic [2:0]  ch;
    logic [15:0] src;
    logic [15:0] dst;
  } itc_xfer_t;
  // channel state
  typedef struct packed {
    logic [15:0] src;
    logic [15:0] dst;
    logic [7:0]  cnt;
    logic        cont;
    logic        word;
    logic        incdst;
  } itc_ch_t;
  typedef enum logic [1:0] {ENT_IDLE, ENT_WAIT, ENT_SHOW} itc_ent_st_t;
endpackage : itc_pkg

// ### itc_ctrl.sv
`timescale 1ns/1ns
`include "itc_map.svh"
module itc_ctrl (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output      logic [31:0]          prdata,
  output      logic                 pready,
  output      logic                 pslverr,
  input  wire logic [7:0]           ext_int,
  input  wire logic [11:0]          src_evt,
  input  wire itc_pkg::itc_hwtrap_t hw_trap,
  input  wire itc_pkg::itc_cpu_t    cpu_i,
  output      itc_pkg::itc_entry_t  entry,
  output      itc_pkg::itc_xfer_t   xfer
);
  import itc_pkg::*;

  localparam int RSP_LO = `ITC_RESP_CYC;     // least response, cycles
  localparam int RSP_HI = `ITC_RESP_MAX_CYC; // longest response, cycles

  logic [31:0]            prdata_r;   // read data latched in setup
  logic                   pready_r;   // access phase answer
  logic                   pslverr_r;  // unmapped address
  logic [`ITC_SCTL_W-1:0] sctl_r [`ITC_NSRC]; // source controls
  itc_ch_t                ch_r [`ITC_NCH];    // transfer channels
  logic [15:0]            tfr_r;      // trap flags
  logic [15:0]            sul_r;      // stack upper limit
  logic [15:0]            sll_r;      // stack lower limit
  logic [15:0]            edge_r;     // edge selects, two per input
  logic [7:0]             ext_q_r;    // previous pin levels
  logic [3:0]             tpnd_r;     // pending trap classes
  logic [1:0]             tact_r;     // trap level in service
  logic                   rst_pend_r; // reset entry owed
  itc_ent_st_t            st_r;       // entry sequencer
  logic [5:0]             wcnt_r;     // response delay count
  logic [4:0]             sel_r;      // source being entered
  itc_entry_t             ent_r;      // presented entry
  itc_xfer_t              xfer_r;     // transfer pulse

  logic                   wr_en;      // write takes effect
  logic [`ITC_NSRC-1:0]   evt;        // source events
  logic                   best_vld;   // some request armed
  logic [4:0]             best_idx;   // winning source
  logic [3:0]             best_prio;  // its priority
  logic [2:0]             best_ch;    // its channel
  logic                   ch_live;    // channel may still serve
  logic                   elig;       // winner may preempt
  logic [1:0]             tp_hi;      // highest pending trap
  logic                   twant;      // trap must be entered
  logic                   idle;       // sequencer idle
  logic                   ch_go;      // channel service now
  logic                   irq_go;     // vectored entry starts
  logic                   acc;        // core accepts entry
  logic                   stk_of;     // overflow on this access
  logic                   stk_uf;     // underflow on this access
  logic [15:0]            tset;       // trap flags to set
  logic [31:0]            rd_data;    // read mux
  logic                   rd_hit;     // address mapped

  // source control address range
  function automatic logic itc_is_src(input logic [11:0] a);
    return a >= `ITC_A_SRC && a < `ITC_A_SRC_END;
  endfunction : itc_is_src

  // channel address range
  function automatic logic itc_is_ch(input logic [11:0] a);
    return a >= `ITC_A_CH && a < `ITC_A_CH_END;
  endfunction : itc_is_ch

  // vector address is four times the trap number
  function automatic logic [15:0] itc_vec(input logic [6:0] n);
    return {7'h00, n, 2'h0}; // RULE8
  endfunction : itc_vec

  // trap number of each source
  function automatic logic [6:0] itc_trapn(input logic [4:0] i);
    logic [6:0] t;
    t = `ITC_TN_OWD;
    if (i < `ITC_SRC_TIM) begin
      t = `ITC_TN_EXT0 + 7'(i); // RULE9
    end else if (i < `ITC_SRC_STX) begin
      t = `ITC_TN_TIM2 + 7'(i - `ITC_SRC_TIM); // RULE10
    end else begin
      unique case (i)
        `ITC_SRC_STX: t = `ITC_TN_STX; // RULE11
        `ITC_SRC_SRX: t = `ITC_TN_SRX;
        `ITC_SRC_SER: t = `ITC_TN_SER;
        `ITC_SRC_STB: t = `ITC_TN_STB;
        `ITC_SRC_SSP: t = `ITC_TN_SSP;
        default:      t = `ITC_TN_OWD;
      endcase
    end
    return t;
  endfunction : itc_trapn

  // build an entry
  function automatic itc_entry_t itc_mk(input logic irq, input logic trap,
                                        input logic [6:0] n, input logic [3:0] l);
    itc_entry_t e;
    e.req  = 1'b1;
    e.irq  = irq;
    e.trap = trap;
    e.num  = n;
    e.vec  = itc_vec(n);
    e.lvl  = l;
    return e;
  endfunction : itc_mk

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign entry   = ent_r;
  assign xfer    = xfer_r;

  assign wr_en = psel & penable & pready_r & pwrite & ~pslverr_r;
  assign idle  = st_r == ENT_IDLE;
  assign acc   = st_r == ENT_SHOW && cpu_i.ack;

  // source events: pin edges and internal strobes
  always_comb begin
    evt = '0;
    for (int i = 0; i < `ITC_NEXT; i++) begin
      evt[i] = (ext_int[i] & ~ext_q_r[i] & edge_r[`ITC_EDGE_W*i+`ITC_EDGE_R]) | // RULE7
               (~ext_int[i] & ext_q_r[i] & edge_r[`ITC_EDGE_W*i+`ITC_EDGE_F]);
    end
    evt[`ITC_NSRC-1:`ITC_NEXT] = src_evt;
  end

  // pick the armed request of highest priority, lowest index on ties
  always_comb begin
    best_vld  = 1'b0;
    best_idx  = '0;
    best_prio = '0;
    for (int i = 0; i < `ITC_NSRC; i++) begin
      if (sctl_r[i][`ITC_F_REQ] && sctl_r[i][`ITC_F_EN] &&
          (!best_vld || sctl_r[i][`ITC_F_PRIO] > best_prio)) begin
        best_vld  = 1'b1;
        best_idx  = 5'(i);
        best_prio = sctl_r[i][`ITC_F_PRIO];
      end
    end
  end

  // routing and service decisions
  assign best_ch = sctl_r[best_idx][`ITC_F_CH];
  assign ch_live = ch_r[best_ch].cont || ch_r[best_ch].cnt != '0; // RULE5
  assign elig    = best_vld && best_prio > cpu_i.lvl && tact_r == '0; // RULE2 RULE16
  assign ch_go   = idle && !rst_pend_r && !twant && elig &&
                   sctl_r[best_idx][`ITC_F_ROUTE] && ch_live; // RULE3
  assign irq_go  = idle && !rst_pend_r && !twant && !cpu_i.sw_trap && elig &&
                   !(sctl_r[best_idx][`ITC_F_ROUTE] && ch_live);

  // highest pending trap class
  always_comb begin
    tp_hi = '0;
    if (tpnd_r[`ITC_TP_NMI]) begin
      tp_hi = `ITC_TL_A1;
    end else if (tpnd_r[`ITC_TP_STO] || tpnd_r[`ITC_TP_STU]) begin
      tp_hi = `ITC_TL_A2;
    end else if (tpnd_r[`ITC_TP_CLB]) begin
      tp_hi = `ITC_TL_B;
    end
  end
  assign twant = tp_hi > tact_r; // RULE15

  // stack limit checks and trap flag sets
  assign stk_of = cpu_i.stk_acc && cpu_i.sp < sul_r; // RULE20
  assign stk_uf = cpu_i.stk_acc && cpu_i.sp > sll_r;
  always_comb begin
    tset              = '0;
    tset[`ITC_TF_NMI] = hw_trap.nmi; // RULE14
    tset[`ITC_TF_STO] = stk_of;
    tset[`ITC_TF_STU] = stk_uf;
    tset[`ITC_TF_UND] = hw_trap.undef_opc;
    tset[`ITC_TF_PRT] = hw_trap.prot_fault;
    tset[`ITC_TF_OPA] = hw_trap.ill_opa;
    tset[`ITC_TF_INA] = hw_trap.ill_ina;
    tset[`ITC_TF_BUS] = hw_trap.ill_bus;
  end

  // read mux
  always_comb begin
    rd_hit  = 1'b1;
    rd_data = '0;
    if (itc_is_src(paddr)) begin
      rd_data = 32'(sctl_r[paddr[`ITC_SRC_IDX]]);
    end else if (itc_is_ch(paddr)) begin
      unique case (paddr[`ITC_CH_FLD])
        `ITC_FLD_SRC: rd_data = 32'(ch_r[paddr[`ITC_CH_IDX]].src);
        `ITC_FLD_DST: rd_data = 32'(ch_r[paddr[`ITC_CH_IDX]].dst);
        `ITC_FLD_CNT: rd_data = 32'(ch_r[paddr[`ITC_CH_IDX]].cnt);
        `ITC_FLD_CTL: rd_data = 32'({ch_r[paddr[`ITC_CH_IDX]].incdst,
                                      ch_r[paddr[`ITC_CH_IDX]].word,
                                      ch_r[paddr[`ITC_CH_IDX]].cont});
      endcase
    end else begin
      unique case (paddr)
        `ITC_A_TFR:  rd_data = 32'(tfr_r);
        `ITC_A_SUL:  rd_data = 32'(sul_r);
        `ITC_A_SLL:  rd_data = 32'(sll_r);
        `ITC_A_STAT: rd_data = 32'({ent_r.req, rst_pend_r, tpnd_r, tact_r});
        `ITC_A_EDGE: rd_data = 32'(edge_r);
        default:     rd_hit  = 1'b0;
      endcase
    end
  end

  // apb answer: ready in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= '0;
    end else begin
      pready_r <= psel && !penable;
      if (psel && !penable) begin
        pslverr_r <= !rd_hit;
        prdata_r  <= pwrite ? '0 : rd_data;
      end
    end
  end

  // source control registers; hardware set wins over any clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `ITC_NSRC; i++) sctl_r[i] <= '0;
    end else begin
      for (int i = 0; i < `ITC_NSRC; i++) begin
        if (wr_en && itc_is_src(paddr) && paddr[`ITC_SRC_IDX] == 5'(i)) begin
          sctl_r[i] <= pwdata[`ITC_SCTL_W-1:0]; // RULE1
          if (evt[i]) sctl_r[i][`ITC_F_REQ] <= 1'b1;
        end else if (evt[i]) begin
          sctl_r[i][`ITC_F_REQ] <= 1'b1; // RULE21
        end else if ((acc && ent_r.irq && sel_r == 5'(i)) ||
                     (ch_go && best_idx == 5'(i))) begin
          sctl_r[i][`ITC_F_REQ] <= 1'b0; // RULE21
        end
      end
    end
  end

  // channels: software setup, pointer and counter update per service
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < `ITC_NCH; c++) ch_r[c] <= '0;
    end else begin
      for (int c = 0; c < `ITC_NCH; c++) begin // RULE6
        if (wr_en && itc_is_ch(paddr) && paddr[`ITC_CH_IDX] == 3'(c)) begin
          unique case (paddr[`ITC_CH_FLD])
            `ITC_FLD_SRC: ch_r[c].src <= pwdata[15:0];
            `ITC_FLD_DST: ch_r[c].dst <= pwdata[15:0];
            `ITC_FLD_CNT: ch_r[c].cnt <= pwdata[7:0];
            `ITC_FLD_CTL: {ch_r[c].incdst, ch_r[c].word, ch_r[c].cont} <= pwdata[2:0];
          endcase
        end else if (ch_go && best_ch == 3'(c)) begin
          if (ch_r[c].incdst) begin
            ch_r[c].dst <= ch_r[c].dst + (ch_r[c].word ? `ITC_INC_W : `ITC_INC_B); // RULE4
          end else begin
            ch_r[c].src <= ch_r[c].src + (ch_r[c].word ? `ITC_INC_W : `ITC_INC_B);
          end
          if (!ch_r[c].cont) ch_r[c].cnt <= ch_r[c].cnt - 8'h01; // RULE5
        end
      end
    end
  end

  // one-cycle transfer pulse toward the bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xfer_r <= '0;
    end else begin
      xfer_r.valid <= ch_go; // RULE4
      if (ch_go) begin
        xfer_r.word <= ch_r[best_ch].word;
        xfer_r.ch   <= best_ch;
        xfer_r.src  <= ch_r[best_ch].src;
        xfer_r.dst  <= ch_r[best_ch].dst;
      end
    end
  end

  // misc software registers; trap flags cleared by writing zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tfr_r   <= '0;
      sul_r   <= '0;
      sll_r   <= '1;
      edge_r  <= '0;
      ext_q_r <= '0;
    end else begin
      ext_q_r <= ext_int;
      tfr_r   <= ((wr_en && paddr == `ITC_A_TFR) ? pwdata[15:0] : tfr_r) | tset; // RULE14
      if (wr_en && paddr == `ITC_A_SUL) sul_r <= pwdata[15:0];
      if (wr_en && paddr == `ITC_A_SLL) sll_r <= pwdata[15:0];
      if (wr_en && paddr == `ITC_A_EDGE) edge_r <= pwdata[15:0];
    end
  end

  // trap bookkeeping: pending classes, level in service, reset entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tpnd_r     <= '0;
      tact_r     <= '0;
      rst_pend_r <= 1'b1; // RULE19
    end else begin
      if (acc && ent_r.trap) begin
        unique case (ent_r.num)
          `ITC_TN_NMI: tpnd_r[`ITC_TP_NMI] <= 1'b0;
          `ITC_TN_STO: tpnd_r[`ITC_TP_STO] <= 1'b0;
          `ITC_TN_STU: tpnd_r[`ITC_TP_STU] <= 1'b0;
          `ITC_TN_CLB: tpnd_r[`ITC_TP_CLB] <= 1'b0;
          default:     rst_pend_r <= 1'b0;
        endcase
        tact_r <= ent_r.num == `ITC_TN_NMI ? `ITC_TL_A1 :
                  ent_r.num == `ITC_TN_CLB ? `ITC_TL_B  :
                  ent_r.num == `ITC_TN_RST ? 2'h0 : `ITC_TL_A2;
      end else if (cpu_i.trap_ret) begin
        tact_r <= '0;
      end
      if (hw_trap.nmi) tpnd_r[`ITC_TP_NMI] <= 1'b1; // RULE13
      if (stk_of) tpnd_r[`ITC_TP_STO] <= 1'b1;
      if (stk_uf) tpnd_r[`ITC_TP_STU] <= 1'b1;
      if (hw_trap.undef_opc | hw_trap.prot_fault | hw_trap.ill_opa |
          hw_trap.ill_ina | hw_trap.ill_bus) tpnd_r[`ITC_TP_CLB] <= 1'b1;
      if (cpu_i.sw_reset || cpu_i.wdt_ovf) rst_pend_r <= 1'b1;
    end
  end

  // entry sequencer: reset, traps, software traps, delayed interrupts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r   <= ENT_IDLE;
      ent_r  <= '0;
      wcnt_r <= '0;
      sel_r  <= '0;
    end else begin
      unique case (st_r)
        ENT_IDLE: begin
          if (rst_pend_r) begin
            ent_r <= itc_mk(1'b0, 1'b1, `ITC_TN_RST, `ITC_LVL_TOP); // RULE19
            st_r  <= ENT_SHOW;
          end else if (twant) begin
            // immediate, no mask applies
            ent_r <= itc_mk(1'b0, 1'b1,
                            tpnd_r[`ITC_TP_NMI] ? `ITC_TN_NMI : // RULE17
                            tpnd_r[`ITC_TP_STO] ? `ITC_TN_STO :
                            tpnd_r[`ITC_TP_STU] ? `ITC_TN_STU : `ITC_TN_CLB, // RULE18
                            `ITC_LVL_TOP); // RULE13
            st_r  <= ENT_SHOW;
          end else if (cpu_i.sw_trap) begin
            ent_r <= itc_mk(1'b0, 1'b0, cpu_i.sw_num, cpu_i.lvl); // RULE8
            st_r  <= ENT_SHOW;
          end else if (irq_go) begin
            sel_r  <= best_idx;
            wcnt_r <= 6'h01;
            st_r   <= ENT_WAIT;
          end
        end
        ENT_WAIT: begin
          if (twant) begin
            // trap takes over; the request stays pending
            st_r <= ENT_IDLE;
          end else if (wcnt_r == 6'(`ITC_RESP_CYC - 1)) begin
            ent_r <= itc_mk(1'b1, 1'b0, itc_trapn(sel_r), sctl_r[sel_r][`ITC_F_PRIO]); // RULE12
            st_r  <= ENT_SHOW;
          end else begin
            wcnt_r <= wcnt_r + 6'h01;
          end
        end
        ENT_SHOW: begin
          if (cpu_i.ack) begin
            ent_r.req <= 1'b0;
            st_r      <= ENT_IDLE;
          end
        end
      endcase
    end
  end

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_irq_take;
    irq_go;
  endsequence
  sequence s_irq_show;
    $rose(ent_r.req) && ent_r.irq;
  endsequence

  a_resp_least: // RULE12
    assert property (s_irq_show |-> $past(idle, RSP_LO) && !$past(idle))
      else $error("interrupt entry faster than least response");
  a_resp_most: // RULE12
    assert property (s_irq_take |-> ##[1:RSP_HI] (ent_r.req || idle))
      else $error("interrupt entry later than longest response");
  a_irq_prio: // RULE2
    assert property (s_irq_show |-> ent_r.lvl > $past(cpu_i.lvl))
      else $error("interrupt without higher priority");
  a_xfer_pulse: // RULE4
    assert property (xfer_r.valid |-> $past(ch_go))
      else $error("transfer without a service cycle");
  a_cnt_dec: // RULE5
    assert property (ch_go && !ch_r[best_ch].cont && !wr_en |=>
                     ch_r[xfer_r.ch].cnt == $past(ch_r[best_ch].cnt) - 8'h01)
      else $error("channel counter not decremented");
  a_trap_calm: // RULE16
    assert property (tact_r != '0 |=> !xfer_r.valid && !$rose(ent_r.irq))
      else $error("trap service preempted by interrupt or channel");
  a_stack_flag: // RULE20
    assert property (stk_of |=> tfr_r[`ITC_TF_STO] && tpnd_r[`ITC_TP_STO])
      else $error("stack overflow not flagged");
  a_nmi_flag: // RULE14
    assert property (hw_trap.nmi |=> tfr_r[`ITC_TF_NMI])
      else $error("nmi flag missing");
  a_trap_vecs: // RULE17
    assert property (ent_r.req && ent_r.trap |-> ent_r.vec[15:2] == 14'(ent_r.num) &&
                     ent_r.vec inside {16'h0000, 16'h0008, 16'h0010, 16'h0018, 16'h0028})
      else $error("trap vector mismatch");
  a_clb_share: // RULE18
    assert property ($rose(ent_r.req) && ent_r.trap && $past(!tpnd_r[`ITC_TP_NMI] &&
                     !tpnd_r[`ITC_TP_STO] && !tpnd_r[`ITC_TP_STU] && !rst_pend_r) |->
                     ent_r.vec == 16'h0028)
      else $error("class b vector wrong");
  a_req_clear: // RULE21
    assert property (acc && ent_r.irq && !evt[sel_r] |=> !sctl_r[$past(sel_r)][`ITC_F_REQ])
      else $error("request not cleared on acceptance");
endmodule : itc_ctrl

// ### itc_core_model.sv
`timescale 1ns/1ns
// core side: acknowledges each entry after a chosen number of cycles
module itc_core_model (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire itc_pkg::itc_entry_t entry,
  input  wire logic [3:0]          dly,
  output      logic                ack
);
  import itc_pkg::*;
  logic [3:0] cnt_r;  // cycles the entry has been shown
  // count while the entry stands, restart when it drops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 4'h0;
    end else if (!entry.req) begin
      cnt_r <= 4'h0;
    end else if (cnt_r != 4'hF) begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
  // ack is a level, held only while the entry is shown
  assign ack = entry.req && (cnt_r >= dly);
endmodule : itc_core_model

// ### itc_ctrl_bench.sv
`timescale 1ns/1ns
module itc_ctrl_bench;
  import itc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er, ack;
  logic [11:0] paddr, src_evt;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  ext_int;
  logic [3:0]  dly;
  itc_hwtrap_t hw;
  itc_cpu_t    cb, cpu_i;
  itc_entry_t  entry;
  itc_xfer_t   xfer;
  int          n_fail, compares, cyc;
  time         t0, lat;
  logic [6:0]  tn [12] = '{7'h22, 7'h23, 7'h24, 7'h25, 7'h26, 7'h27,
                           7'h2A, 7'h2B, 7'h2C, 7'h47, 7'h41, 7'h43};
  always #5 pclk = ~pclk;
  // core inputs from the bench, ack from the core model
  always_comb begin
    cpu_i = cb;
    cpu_i.ack = ack;
  end
  itc_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_int(ext_int), .src_evt(src_evt), .hw_trap(hw),
    .cpu_i(cpu_i), .entry(entry), .xfer(xfer));
  itc_core_model core (.pclk(pclk), .presetn(presetn), .entry(entry), .dly(dly), .ack(ack));
  task automatic give_verdict;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one apb transfer, waits for pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    // only the run bound ends this wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  function automatic logic [24:0] ex(input logic i, input logic t, input logic [6:0] n);
    return {i, t, n, 7'h00, n, 2'b00};
  endfunction : ex
  // wait for the acknowledged entry and compare its kind, number and vector
  task automatic ent(input logic [24:0] e);
    int k;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (!(entry.req === 1'b1 && ack === 1'b1) && k < 200);
    lat = $time - t0;
    chk("entry", {2'b11, e}, {entry.req, ack, entry.irq, entry.trap, entry.num, entry.vec});
  endtask : ent
  task automatic ev(input int b);
    @(posedge pclk);
    src_evt <= 12'h001 << b;
    t0 = $time;
    @(posedge pclk);
    src_evt <= 12'h000;
  endtask : ev
  task automatic quiet;
    logic s;
    s = 1'b0;
    repeat (40) begin
      @(posedge pclk);
      s = s | entry.req;
    end
    chk("quiet", 0, s);
  endtask : quiet
  task automatic hwp(input itc_hwtrap_t v);
    @(posedge pclk);
    hw <= v;
    @(posedge pclk);
    hw <= '0;
  endtask : hwp
  task automatic tret;
    @(posedge pclk);
    cb.trap_ret <= 1'b1;
    @(posedge pclk);
    cb.trap_ret <= 1'b0;
  endtask : tret
  task automatic xw(input logic [35:0] e);
    int k;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (xfer.valid !== 1'b1 && k < 50);
    chk("xfer", {1'b1, e}, {xfer.valid, xfer.word, xfer.ch, xfer.src, xfer.dst});
  endtask : xw
  // bound on the whole run
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      give_verdict();
    end
  end
  initial begin
    pclk    = 1'b0;
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = '0;
    pwdata  = '0;
    ext_int = '0;
    src_evt = '0;
    hw      = '0;
    cb      = '0;
    dly     = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    ent(ex(0, 1, 7'h00));
    apb(0, 12'h208, 0);
    chk("lower", 32'hFFFF, rd);
    apb(0, 12'h300, 0);
    chk("unmapped", 1, er);
    // every timer, serial, sync port and watchdog source, enabled at priority one
    for (int i = 0; i < 12; i++) begin
      apb(1, 12'(4 * (i + 8)), 32'h6);
      ev(i);
      ent(ex(1, 0, tn[i]));
      if (i == 0) chk("resp", 1, lat >= 200 && lat <= 480);
      dly <= 4'h3;
      apb(0, 12'(4 * (i + 8)), 0);
      chk("ctl", 32'h6, rd);
    end
    cb.lvl <= 4'h5;
    apb(1, 12'h020, 32'h16);
    ev(0);
    quiet();
    cb.lvl <= 4'h4;
    ent(ex(1, 0, 7'h22));
    chk("level", 4'h5, entry.lvl);
    cb.lvl <= 4'h0;
    apb(1, 12'h210, 32'h40);
    apb(1, 12'h00C, 32'h6);
    ext_int <= 8'h08;
    ent(ex(1, 0, 7'h1B));
    ext_int <= 8'h00;
    quiet();
    apb(1, 12'h210, 32'h80);
    ext_int <= 8'h08;
    quiet();
    ext_int <= 8'h00;
    ent(ex(1, 0, 7'h1B));
    // both edges selected: rise and fall each give an entry
    apb(1, 12'h210, 32'hC0);
    ext_int <= 8'h08;
    ent(ex(1, 0, 7'h1B));
    ext_int <= 8'h00;
    ent(ex(1, 0, 7'h1B));
    hwp(6'b10_0000);
    ent(ex(0, 1, 7'h02));
    tret();
    hwp(6'b01_0000);
    ent(ex(0, 1, 7'h0A));
    tret();
    apb(1, 12'h204, 32'h100);
    cb.stk_acc <= 1'b1;
    cb.sp <= 16'h0080;
    @(posedge pclk);
    cb.stk_acc <= 1'b0;
    ent(ex(0, 1, 7'h04));
    tret();
    apb(0, 12'h200, 0);
    chk("flags", 32'hC080, rd);
    cb.sw_num <= 7'h7F;
    cb.sw_trap <= 1'b1;
    ent(ex(0, 0, 7'h7F));
    cb.sw_trap <= 1'b0;
    // software reset owes a fresh reset entry
    cb.sw_reset <= 1'b1;
    @(posedge pclk);
    cb.sw_reset <= 1'b0;
    ent(ex(0, 1, 7'h00));
    // channel two, word moves, source pointer steps, two transfers
    apb(1, 12'h120, 32'h1000);
    apb(1, 12'h124, 32'h2000);
    apb(1, 12'h128, 32'h2);
    apb(1, 12'h12C, 32'h2);
    apb(1, 12'h024, 32'h14E);
    ev(1);
    xw({1'b1, 3'd2, 16'h1000, 16'h2000});
    ev(1);
    xw({1'b1, 3'd2, 16'h1002, 16'h2000});
    ev(1);
    ent(ex(1, 0, 7'h23));
    apb(0, 12'h128, 0);
    chk("count", 0, rd);
    give_verdict();
  end
endmodule : itc_ctrl_bench
